// ==== pkg/vfd_defines.svh ====
// constants for the vliw fetch and dispatch core
`ifndef VFD_DEFINES_SVH
`define VFD_DEFINES_SVH
`define VFD_SLOTS 8
`define VFD_INSN_W 32
`define VFD_FP_W 256
`define VFD_FP_BYTES 32'h0000_0020
`define VFD_FP_ALIGN 5
`define VFD_RF_DEPTH 16
`define VFD_CIRC_BYTES 32'h0000_0400
`define VFD_CHAIN_BIT 0
`define VFD_OP_RANGE 4:1
`define VFD_UNIT_RANGE 7:5
`define VFD_OFF15_RANGE 22:8
`define VFD_LONG_BIT 12
`define VFD_SRC1_RANGE 17:13
`define VFD_SRC2_RANGE 22:18
`define VFD_DST_RANGE 27:23
`define VFD_ZERO_BIT 28
`define VFD_CREG_RANGE 31:29
`define VFD_U_L_A 3'h0
`define VFD_U_S_A 3'h1
`define VFD_U_M_A 3'h2
`define VFD_U_D_A 3'h3
`define VFD_U_D_B 3'h4
`define VFD_U_M_B 3'h5
`define VFD_U_S_B 3'h6
`define VFD_U_L_B 3'h7
`define VFD_OP_ADD 4'h0
`define VFD_OP_SUB 4'h1
`define VFD_OP_AND 4'h2
`define VFD_OP_OR 4'h3
`define VFD_OP_XOR 4'h4
`define VFD_OP_SHL 4'h5
`define VFD_OP_SHR 4'h6
`define VFD_OP_BRANCH 4'h7
`define VFD_OP_MPYS 4'h1
`define VFD_OP_NOP 4'hF
`define VFD_D_STORE_BIT 4
`define VFD_D_CIRC_BIT 3
`define VFD_D_SIZE_RANGE 2:1
`define VFD_SZ_BYTE 2'h0
`define VFD_SZ_HALF 2'h1
`define VFD_SZ_WORD 2'h2
`define VFD_CREG_ALWAYS 3'h0
`endif

// ==== pkg/vfd_pkg.sv ====
// types shared by the vliw fetch and dispatch core
`default_nettype none
package vfd_pkg;
    typedef enum logic [1:0] {VFD_FETCH, VFD_DISPATCH} vfd_state_e;
    typedef enum logic [1:0] {VFD_KIND_L, VFD_KIND_S, VFD_KIND_M, VFD_KIND_D} vfd_kind_e;
    typedef logic [31:0] vfd_word_t;
endpackage : vfd_pkg
`default_nettype wire

// ==== rtl/vfd_regfile.sv ====
// one side's general-purpose register file with several write ports
`timescale 1ns/1ns
`default_nettype none
`include "vfd_defines.svh"
module vfd_regfile #(
    parameter int NWR = 10,
    parameter int DEPTH = `VFD_RF_DEPTH
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [NWR-1:0] i_we,
    input wire logic [NWR*$clog2(DEPTH)-1:0] i_waddr,
    input wire logic [NWR*32-1:0] i_wdata,
    output logic [DEPTH*32-1:0] o_regs
);
    localparam int AW = $clog2(DEPTH);
    logic [31:0] mem [DEPTH];
    logic [31:0] next_mem [DEPTH];

    // ------------------------------------------------------------
    // write ports, higher port wins on the same register
    // ------------------------------------------------------------
    always_comb begin
        for (int r = 0; r < DEPTH; r++) begin
            next_mem[r] = mem[r];
        end
        for (int p = 0; p < NWR; p++) begin
            if (i_we[p]) begin
                next_mem[i_waddr[p*AW +: AW]] = i_wdata[p*32 +: 32];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int r = 0; r < DEPTH; r++) begin
                mem[r] <= 32'h0000_0000;
            end
        end else begin
            for (int r = 0; r < DEPTH; r++) begin
                mem[r] <= next_mem[r];
            end
        end
    end

    // all registers visible at once so every unit reads in one cycle
    always_comb begin
        for (int r = 0; r < DEPTH; r++) begin
            o_regs[r*32 +: 32] = mem[r];
        end
    end
endmodule : vfd_regfile
`default_nettype wire

// ==== rtl/vfd_addr_gen.sv ====
// address, byte-lane and store-data former for one addressing unit
`timescale 1ns/1ns
`default_nettype none
`include "vfd_defines.svh"
module vfd_addr_gen #(
    parameter logic [31:0] CIRC_BYTES = `VFD_CIRC_BYTES
) (
    input wire logic [31:0] i_base,
    input wire logic [4:0] i_off5,
    input wire logic [14:0] i_off15,
    input wire logic i_long,
    input wire logic i_circ,
    input wire logic [1:0] i_size,
    input wire logic [31:0] i_data,
    output logic [31:0] o_addr,
    output logic [3:0] o_be,
    output logic [31:0] o_wdata
);
    logic [31:0] off;
    logic [31:0] lin;

    always_comb begin
        off = i_long ? {17'h0_0000, i_off15} : {27'h000_0000, i_off5};
        off = off << i_size;
        lin = i_base + off;
        o_addr = i_circ ? ((i_base & ~(CIRC_BYTES - 32'h0000_0001)) | (lin & (CIRC_BYTES - 32'h0000_0001))) : lin;
        case (i_size)
            `VFD_SZ_BYTE: begin
                o_be = 4'(4'h1 << o_addr[1:0]);
                o_wdata = {4{i_data[7:0]}};
            end
            `VFD_SZ_HALF: begin
                o_be = 4'(4'h3 << {o_addr[1], 1'b0});
                o_wdata = {2{i_data[15:0]}};
            end
            default: begin
                o_be = 4'hF;
                o_wdata = i_data;
            end
        endcase
    end
endmodule : vfd_addr_gen
`default_nettype wire

// ==== rtl/vfd_core.sv ====
// fetch, execute-packet split, dispatch and two-sided datapath of the core
`timescale 1ns/1ns
`default_nettype none
`include "vfd_defines.svh"
module vfd_core #(
    parameter logic [31:0] RESET_PC = 32'h0000_0000,
    parameter logic [31:0] CIRC_BYTES = `VFD_CIRC_BYTES
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    output logic o_pm_req,
    output logic [31:0] o_pm_addr,
    input wire logic i_pm_valid,
    input wire logic [`VFD_FP_W-1:0] i_pm_data,
    output logic [1:0] o_dm_req,
    output logic [1:0] o_dm_we,
    output logic [63:0] o_dm_addr,
    output logic [7:0] o_dm_be,
    output logic [63:0] o_dm_wdata,
    input wire logic [1:0] i_dm_rvalid,
    input wire logic [63:0] i_dm_rdata,
    output logic [`VFD_SLOTS-1:0] o_issue,
    output logic o_unit_clash,
    output logic o_cross_drop
);
    localparam int NS = `VFD_SLOTS;
    localparam int NWR = `VFD_SLOTS + 2;
    localparam int RW = `VFD_RF_DEPTH * 32;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rd_reg(input logic [4:0] r, input logic [RW-1:0] a, input logic [RW-1:0] b);
        rd_reg = r[4] ? b[r[3:0]*32 +: 32] : a[r[3:0]*32 +: 32];
    endfunction : rd_reg

    function automatic vfd_pkg::vfd_kind_e unit_kind(input logic [2:0] u);
        case (u)
            `VFD_U_L_A, `VFD_U_L_B: unit_kind = vfd_pkg::VFD_KIND_L;
            `VFD_U_S_A, `VFD_U_S_B: unit_kind = vfd_pkg::VFD_KIND_S;
            `VFD_U_M_A, `VFD_U_M_B: unit_kind = vfd_pkg::VFD_KIND_M;
            default: unit_kind = vfd_pkg::VFD_KIND_D;
        endcase
    endfunction : unit_kind

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    vfd_pkg::vfd_state_e state, next_state;
    logic [31:0] pc, next_pc;
    logic [31:0] fp [NS];
    logic [31:0] next_fp [NS];
    logic [2:0] ptr, next_ptr;
    logic [1:0] ld_pend, next_ld_pend;
    logic [4:0] ld_dst [2];
    logic [4:0] next_ld_dst [2];
    logic [1:0] ld_size [2];
    logic [1:0] next_ld_size [2];
    logic [1:0] ld_lo [2];
    logic [1:0] next_ld_lo [2];
    logic next_pm_req, next_unit_clash, next_cross_drop;
    logic [31:0] next_pm_addr;
    logic [1:0] next_dm_req, next_dm_we;
    logic [63:0] next_dm_addr, next_dm_wdata;
    logic [7:0] next_dm_be;
    logic [NS-1:0] next_issue;

    logic [RW-1:0] regs_a, regs_b;
    logic [NWR-1:0] we_a, we_b;
    logic [NWR*4-1:0] wa_a, wa_b;
    logic [NWR*32-1:0] wd_a, wd_b;
    logic [NS-1:0] grp;
    logic [2:0] last;
    logic clash, xdrop, take_br;
    logic [31:0] br_target;
    logic [NS-1:0] u_act, u_go;
    logic [31:0] u_ins [NS];
    logic [1:0] d_go;
    logic [31:0] d_base [2];
    logic [31:0] d_data [2];
    logic [31:0] d_ins [2];
    logic [31:0] ag_addr [2];
    logic [3:0] ag_be [2];
    logic [31:0] ag_wdata [2];

    // two side files of sixteen words
    vfd_regfile #(.NWR(NWR), .DEPTH(`VFD_RF_DEPTH)) u_rf_a (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_we(we_a), .i_waddr(wa_a), .i_wdata(wd_a), .o_regs(regs_a)
    );
    vfd_regfile #(.NWR(NWR), .DEPTH(`VFD_RF_DEPTH)) u_rf_b (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_we(we_b), .i_waddr(wa_b), .i_wdata(wd_b), .o_regs(regs_b)
    );

    // ------------------------------------------------------------
    // execute packet split and unit steering
    // ------------------------------------------------------------
    always_comb begin
        logic open;
        logic [2:0] u;
        open = 1'b1;
        u = 3'h0;
        last = 3'(NS - 1);
        clash = 1'b0;
        grp = '0;
        u_act = '0;
        for (int k = 0; k < NS; k++) begin
            u_ins[k] = 32'h0000_0000;
        end
        for (int s = 0; s < NS; s++) begin
            if (state == vfd_pkg::VFD_DISPATCH && open && 3'(s) >= ptr) begin
                grp[s] = 1'b1;
                if (!fp[s][`VFD_CHAIN_BIT]) begin
                    open = 1'b0;
                    last = 3'(s);
                end
            end
        end
        for (int s = 0; s < NS; s++) begin
            u = fp[s][`VFD_UNIT_RANGE];
            // each unit takes one slot per packet
            if (grp[s] && u_act[u]) begin
                clash = 1'b1;
            end else if (grp[s]) begin
                u_act[u] = 1'b1;
                u_ins[u] = fp[s];
            end
        end
    end

    // ------------------------------------------------------------
    // per-unit execution, cross-path limits and write-back
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] ins, a, b, c, res;
        logic side, cond, wr, st;
        logic [3:0] op;
        logic [4:0] s1, s2, dst;
        logic [1:0] nxr;
        logic [1:0] xr_used, xw_used;
        vfd_pkg::vfd_kind_e kd;
        ins = '0;
        a = '0;
        b = '0;
        c = '0;
        res = '0;
        side = 1'b0;
        cond = 1'b0;
        wr = 1'b0;
        st = 1'b0;
        op = 4'h0;
        s1 = 5'h00;
        s2 = 5'h00;
        dst = 5'h00;
        nxr = 2'h0;
        kd = vfd_pkg::VFD_KIND_L;
        xr_used = '0;
        xw_used = '0;
        xdrop = 1'b0;
        take_br = 1'b0;
        br_target = 32'h0000_0000;
        u_go = '0;
        d_go = '0;
        we_a = '0;
        we_b = '0;
        wa_a = '0;
        wa_b = '0;
        wd_a = '0;
        wd_b = '0;
        for (int p = 0; p < 2; p++) begin
            d_base[p] = 32'h0000_0000;
            d_data[p] = 32'h0000_0000;
            d_ins[p] = 32'h0000_0000;
        end
        for (int k = 0; k < NS; k++) begin
            ins = u_ins[k];
            // unit code bit two selects the side
            side = k[2];
            kd = unit_kind(3'(k));
            op = ins[`VFD_OP_RANGE];
            s1 = ins[`VFD_SRC1_RANGE];
            s2 = ins[`VFD_SRC2_RANGE];
            dst = ins[`VFD_DST_RANGE];
            st = (kd == vfd_pkg::VFD_KIND_D) && ins[`VFD_D_STORE_BIT];
            // every operand read combinationally, no stall
            a = rd_reg(s1, regs_a, regs_b);
            b = rd_reg(s2, regs_a, regs_b);
            c = rd_reg(dst, regs_a, regs_b);
            cond = (ins[`VFD_CREG_RANGE] == `VFD_CREG_ALWAYS) ||
                   ((rd_reg({2'b00, ins[`VFD_CREG_RANGE]}, regs_a, regs_b) == 32'h0000_0000) == ins[`VFD_ZERO_BIT]);
            // opposite-file operands ride the cross bus
            if (kd == vfd_pkg::VFD_KIND_D) begin
                nxr = 2'((s2[4] != side) ? 1 : 0) + 2'((st && dst[4] != side) ? 1 : 0);
            end else begin
                nxr = 2'((s1[4] != side) ? 1 : 0) + 2'((s2[4] != side) ? 1 : 0);
            end
            wr = !st && !(kd == vfd_pkg::VFD_KIND_S && op == `VFD_OP_BRANCH);
            res = 32'h0000_0000;
            case (kd)
                vfd_pkg::VFD_KIND_M: begin
                    res = (op == `VFD_OP_MPYS) ? 32'($signed(a[15:0]) * $signed(b[15:0])) : a[15:0] * b[15:0];
                end
                vfd_pkg::VFD_KIND_D: res = 32'h0000_0000;
                default: begin
                    case (op)
                        `VFD_OP_ADD: res = a + b;
                        `VFD_OP_SUB: res = a - b;
                        `VFD_OP_AND: res = a & b;
                        `VFD_OP_OR: res = a | b;
                        `VFD_OP_XOR: res = a ^ b;
                        `VFD_OP_SHL: res = a << b[4:0];
                        `VFD_OP_SHR: res = a >> b[4:0];
                        default: res = 32'h0000_0000;
                    endcase
                end
            endcase
            // nop padding slots never issue
            if (u_act[k] && op != `VFD_OP_NOP && cond) begin
                // one cross read and one cross write
                if (nxr > 2'd1 || (nxr == 2'd1 && xr_used[side]) || (wr && dst[4] != side && xw_used[dst[4]])) begin
                    xdrop = 1'b1;
                end else begin
                    u_go[k] = 1'b1;
                    if (nxr == 2'd1) begin
                        xr_used[side] = 1'b1;
                    end
                    if (wr && dst[4] != side) begin
                        xw_used[dst[4]] = 1'b1;
                    end
                    if (kd == vfd_pkg::VFD_KIND_S && op == `VFD_OP_BRANCH) begin
                        take_br = 1'b1;
                        br_target = b;
                    end
                    // only addressing units reach data memory
                    if (kd == vfd_pkg::VFD_KIND_D) begin
                        d_go[side] = 1'b1;
                        d_base[side] = b;
                        d_data[side] = c;
                        d_ins[side] = ins;
                    end else if (dst[4]) begin
                        we_b[k] = 1'b1;
                        wa_b[k*4 +: 4] = dst[3:0];
                        wd_b[k*32 +: 32] = res;
                    end else begin
                        we_a[k] = 1'b1;
                        wa_a[k*4 +: 4] = dst[3:0];
                        wd_a[k*32 +: 32] = res;
                    end
                end
            end
        end
        for (int p = 0; p < 2; p++) begin
            res = i_dm_rdata[p*32 +: 32] >> {ld_lo[p], 3'b000};
            if (ld_size[p] == `VFD_SZ_BYTE) begin
                res = {24'h00_0000, res[7:0]};
            end else if (ld_size[p] == `VFD_SZ_HALF) begin
                res = {16'h0000, res[15:0]};
            end
            if (ld_pend[p] && i_dm_rvalid[p]) begin
                we_a[NS+p] = !ld_dst[p][4];
                we_b[NS+p] = ld_dst[p][4];
                wa_a[(NS+p)*4 +: 4] = ld_dst[p][3:0];
                wa_b[(NS+p)*4 +: 4] = ld_dst[p][3:0];
                wd_a[(NS+p)*32 +: 32] = res;
                wd_b[(NS+p)*32 +: 32] = res;
            end
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_ag
        vfd_addr_gen #(.CIRC_BYTES(CIRC_BYTES)) u_ag (
            .i_base(d_base[p]),
            .i_off5(d_ins[p][`VFD_SRC1_RANGE]),
            .i_off15(d_ins[p][`VFD_OFF15_RANGE]),
            .i_long(d_ins[p][`VFD_LONG_BIT]),
            .i_circ(d_ins[p][`VFD_D_CIRC_BIT]),
            .i_size(d_ins[p][`VFD_D_SIZE_RANGE]),
            .i_data(d_data[p]),
            .o_addr(ag_addr[p]),
            .o_be(ag_be[p]),
            .o_wdata(ag_wdata[p])
        );
    end

    // ------------------------------------------------------------
    // fetch and dispatch sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_pc = pc;
        next_ptr = ptr;
        next_ld_pend = ld_pend & ~i_dm_rvalid;
        for (int s = 0; s < NS; s++) begin
            next_fp[s] = fp[s];
        end
        for (int p = 0; p < 2; p++) begin
            next_ld_dst[p] = ld_dst[p];
            next_ld_size[p] = ld_size[p];
            next_ld_lo[p] = ld_lo[p];
            next_dm_req[p] = d_go[p];
            next_dm_we[p] = d_go[p] && d_ins[p][`VFD_D_STORE_BIT];
            next_dm_addr[p*32 +: 32] = ag_addr[p];
            next_dm_be[p*4 +: 4] = ag_be[p];
            next_dm_wdata[p*32 +: 32] = ag_wdata[p];
            if (d_go[p] && !d_ins[p][`VFD_D_STORE_BIT]) begin
                next_ld_pend[p] = 1'b1;
                next_ld_dst[p] = d_ins[p][`VFD_DST_RANGE];
                next_ld_size[p] = d_ins[p][`VFD_D_SIZE_RANGE];
                next_ld_lo[p] = ag_addr[p][1:0];
            end
        end
        case (state)
            vfd_pkg::VFD_FETCH: begin
                // one whole fetch packet of eight slots
                if (o_pm_req && i_pm_valid) begin
                    for (int s = 0; s < NS; s++) begin
                        next_fp[s] = i_pm_data[s*32 +: 32];
                    end
                    next_ptr = 3'h0;
                    next_pc = pc + `VFD_FP_BYTES;
                    next_state = vfd_pkg::VFD_DISPATCH;
                end
            end
            vfd_pkg::VFD_DISPATCH: begin
                next_ptr = 3'(last + 3'h1);
                if (take_br) begin
                    next_pc = {br_target[31:`VFD_FP_ALIGN], {`VFD_FP_ALIGN{1'b0}}};
                    next_state = vfd_pkg::VFD_FETCH;
                // up to eight packets, then refetch
                end else if (last == 3'(NS - 1)) begin
                    next_state = vfd_pkg::VFD_FETCH;
                end
            end
            default: next_state = vfd_pkg::VFD_FETCH;
        endcase
        next_pm_req = (next_state == vfd_pkg::VFD_FETCH);
        next_pm_addr = next_pc;
        next_issue = u_go;
        next_unit_clash = clash;
        next_cross_drop = xdrop;
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= vfd_pkg::VFD_FETCH;
            pc <= RESET_PC;
            ptr <= 3'h0;
            ld_pend <= 2'b00;
            for (int s = 0; s < NS; s++) begin
                fp[s] <= 32'h0000_0000;
            end
            for (int p = 0; p < 2; p++) begin
                ld_dst[p] <= 5'h00;
                ld_size[p] <= 2'h0;
                ld_lo[p] <= 2'h0;
            end
            o_pm_req <= 1'b0;
            o_pm_addr <= RESET_PC;
            o_dm_req <= 2'b00;
            o_dm_we <= 2'b00;
            o_dm_addr <= 64'h0000_0000_0000_0000;
            o_dm_be <= 8'h00;
            o_dm_wdata <= 64'h0000_0000_0000_0000;
            o_issue <= '0;
            o_unit_clash <= 1'b0;
            o_cross_drop <= 1'b0;
        end else begin
            state <= next_state;
            pc <= next_pc;
            ptr <= next_ptr;
            ld_pend <= next_ld_pend;
            for (int s = 0; s < NS; s++) begin
                fp[s] <= next_fp[s];
            end
            for (int p = 0; p < 2; p++) begin
                ld_dst[p] <= next_ld_dst[p];
                ld_size[p] <= next_ld_size[p];
                ld_lo[p] <= next_ld_lo[p];
            end
            o_pm_req <= next_pm_req;
            o_pm_addr <= next_pm_addr;
            o_dm_req <= next_dm_req;
            o_dm_we <= next_dm_we;
            o_dm_addr <= next_dm_addr;
            o_dm_be <= next_dm_be;
            o_dm_wdata <= next_dm_wdata;
            o_issue <= next_issue;
            o_unit_clash <= next_unit_clash;
            o_cross_drop <= next_cross_drop;
        end
    end
endmodule : vfd_core
`default_nettype wire

// ==== test/vfd_mem_model.sv ====
// program and data memory model on the far side of the core
`timescale 1ns/1ns
`default_nettype none
module vfd_mem_model (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_pm_req,
    input wire logic [31:0] i_pm_addr,
    output logic o_pm_valid,
    output logic [255:0] o_pm_data,
    input wire logic [1:0] i_dm_req,
    input wire logic [1:0] i_dm_we,
    output logic [1:0] o_dm_rvalid,
    output logic [63:0] o_dm_rdata
);
    // fixed program, slot 0 in the low bits, nop padding elsewhere
    function automatic logic [255:0] pkt(input logic [2:0] n);
        case (n)
            3'h0: pkt = '0;
            3'h1: pkt = {32'h0842_00E0, 32'h0842_00C1, 32'h0842_00A1, 32'h0AC2_0081,
                32'h0280_0061, 32'h0000_0041, 32'h0000_0021, 32'h0000_0001};
            3'h2: pkt = {{5{32'h0000_001E}}, 32'h0042_0000, 32'h0000_0000, 32'h0000_0001};
            3'h3: pkt = {{5{32'h0000_001E}}, 32'h0000_6070, 32'h0280_2074, 32'h2000_0000};
            default: pkt = {8{32'h0000_001E}};
        endcase
    endfunction : pkt
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pm_valid <= 1'b0;
            o_dm_rvalid <= 2'h0;
        end else begin
            o_pm_valid <= i_pm_req && !o_pm_valid;
            o_dm_rvalid <= i_dm_req & ~i_dm_we;
        end
    end
    // lines carry the inverse while o_pm_valid, or for both data lanes o_dm_rvalid[0], is low so stale data cannot match
    assign o_pm_data = o_pm_valid ? pkt(i_pm_addr[7:5]) : ~pkt(i_pm_addr[7:5]);
    assign o_dm_rdata = {2{o_dm_rvalid[0] ? 32'h0000_1234 : 32'hFFFF_EDCB}};
endmodule : vfd_mem_model
`default_nettype wire

// ==== test/vfd_core_asserts.sv ====
// port checks for the fetch and dispatch core
`timescale 1ns/1ns
`default_nettype none
module vfd_core_asserts (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic o_pm_req,
    input wire logic [31:0] o_pm_addr,
    input wire logic i_pm_valid,
    input wire logic [7:0] o_issue,
    input wire logic [1:0] o_dm_req,
    input wire logic [1:0] o_dm_we,
    input wire logic [63:0] o_dm_addr,
    input wire logic [7:0] o_dm_be,
    input wire logic [63:0] o_dm_wdata
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);
    // lanes must form a byte, half or word pattern that fits the low address bits
    function automatic logic be_ok(input logic [3:0] be, input logic [1:0] a);
        be_ok = (be == (4'h1 << a)) || (be == (4'h3 << a) && !a[0]) || (be == 4'hF && a == 2'h0);
    endfunction : be_ok
    sequence s_take;
        o_pm_req && i_pm_valid;
    endsequence
    sequence s_wait;
        o_pm_req && !i_pm_valid;
    endsequence
    property p_al; o_pm_req |-> o_pm_addr[4:0] == 5'h00; endproperty
    a_al: assert property (p_al) else $error("fetch misaligned");
    property p_hold; s_wait |=> o_pm_req && $stable(o_pm_addr); endproperty
    a_hold: assert property (p_hold) else $error("fetch not held");
    property p_drop; s_take |=> !o_pm_req; endproperty
    a_drop: assert property (p_drop) else $error("fetch not dropped");
    property p_iss; o_issue != 8'h00 && o_pm_req |-> $rose(o_pm_req); endproperty
    a_iss: assert property (p_iss) else $error("issue while fetching");
    property p_dm; o_dm_req != 2'h0 && o_pm_req |-> $rose(o_pm_req); endproperty
    a_dm: assert property (p_dm) else $error("access while fetching");
    property p_bea; o_dm_req[0] |-> be_ok(o_dm_be[3:0], o_dm_addr[1:0]); endproperty
    a_bea: assert property (p_bea) else $error("bad lanes a");
    property p_beb; o_dm_req[1] |-> be_ok(o_dm_be[7:4], o_dm_addr[33:32]); endproperty
    a_beb: assert property (p_beb) else $error("bad lanes b");
    property p_rep; o_dm_req[0] && o_dm_we[0] && o_dm_be[3:0] != 4'hF |-> o_dm_wdata[31:16] == o_dm_wdata[15:0];
    endproperty
    a_rep: assert property (p_rep) else $error("store data not replicated");
endmodule : vfd_core_asserts
bind vfd_core vfd_core_asserts chk_u (.i_mclk, .i_resetn, .o_pm_req, .o_pm_addr, .i_pm_valid, .o_issue,
    .o_dm_req, .o_dm_we, .o_dm_addr, .o_dm_be, .o_dm_wdata);
`default_nettype wire

// ==== test/vliw_fetch_dispatch_core_tb.sv ====
// self-checking bench for the fetch and dispatch core
`timescale 1ns/1ns
`default_nettype none
`define VFD_CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t mismatch", $time); end end
module vliw_fetch_dispatch_core_tb;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic pm_req, pm_valid, clash, xdrop;
    logic [1:0] dm_req, dm_we, dm_rvalid;
    logic [7:0] issue, dm_be;
    logic [31:0] pm_addr;
    logic [63:0] dm_addr, dm_wdata, dm_rdata;
    logic [255:0] pm_data;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int t0, t1, t2;
    always #25 i_mclk = ~i_mclk;
    always @(posedge i_mclk) cyc <= cyc + 1;
    vfd_core dut_u (.i_mclk, .i_resetn, .o_pm_req(pm_req), .o_pm_addr(pm_addr), .i_pm_valid(pm_valid),
        .i_pm_data(pm_data), .o_dm_req(dm_req), .o_dm_we(dm_we), .o_dm_addr(dm_addr), .o_dm_be(dm_be),
        .o_dm_wdata(dm_wdata), .i_dm_rvalid(dm_rvalid), .i_dm_rdata(dm_rdata), .o_issue(issue),
        .o_unit_clash(clash), .o_cross_drop(xdrop));
    vfd_mem_model mem_u (.i_mclk, .i_resetn, .i_pm_req(pm_req), .i_pm_addr(pm_addr), .o_pm_valid(pm_valid),
        .o_pm_data(pm_data), .i_dm_req(dm_req), .i_dm_we(dm_we), .o_dm_rvalid(dm_rvalid), .o_dm_rdata(dm_rdata));
    task automatic wait_take(input logic [31:0] a, output int t);
        for (int n = 0; n < 60 && !(pm_req === 1'b1 && pm_valid === 1'b1); n++) @(negedge i_mclk);
        `VFD_CHK(pm_addr, a)
        t = cyc;
        @(negedge i_mclk);
    endtask : wait_take
    task automatic wait_issue;
        for (int n = 0; n < 20 && issue === 8'h00; n++) @(negedge i_mclk);
    endtask : wait_issue
    task automatic t_singles;
        wait_take(32'h0000_0000, t0);
        wait_issue();
        for (int k = 0; k < 8; k++) begin
            `VFD_CHK(issue, 8'h01)
            @(negedge i_mclk);
        end
        `VFD_CHK(issue, 8'h00)
    endtask : t_singles
    task automatic t_wide;
        wait_take(32'h0000_0020, t1);
        wait_issue();
        `VFD_CHK(issue, 8'hFF)
        `VFD_CHK({dm_req, dm_we}, 4'hC)
        `VFD_CHK(dm_addr, 64'h0000_0010_0000_0000)
        `VFD_CHK(dm_be, 8'h11)
        `VFD_CHK(xdrop, 1'b0)
    endtask : t_wide
    task automatic t_clash;
        int hits;
        logic [7:0] first;
        int xh;
        hits = 0;
        xh = 0;
        first = 8'h00;
        wait_take(32'h0000_0040, t2);
        `VFD_CHK(t1 - t0 - (t2 - t1), 7)
        for (int k = 0; k < 6; k++) begin
            hits += int'(clash === 1'b1);
            xh += int'(xdrop === 1'b1);
            if (first === 8'h00) first = issue;
            @(negedge i_mclk);
        end
        `VFD_CHK(hits, 1)
        `VFD_CHK(xh, 1)
        `VFD_CHK(first, 8'h01)
    endtask : t_clash
    task automatic t_store;
        int hits;
        hits = 0;
        wait_take(32'h0000_0060, t0);
        for (int n = 0; n < 20 && dm_req === 2'h0; n++) begin
            hits += int'(issue[0] === 1'b1);
            @(negedge i_mclk);
        end
        `VFD_CHK(hits, 0)
        `VFD_CHK(issue, 8'h08)
        `VFD_CHK({dm_req, dm_we[0], dm_be[3:0]}, 7'h3F)
        `VFD_CHK(dm_addr[31:0], 32'h0000_0004)
        `VFD_CHK(dm_wdata[31:0], 32'h0000_0034)
        @(negedge i_mclk);
        `VFD_CHK({dm_req, dm_be[3:0]}, 6'h18)
        `VFD_CHK(dm_addr[31:0], 32'h0000_0003)
    endtask : t_store
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(posedge i_mclk);
        i_resetn <= 1'b1;
        @(negedge i_mclk);
        t_singles();
        t_wide();
        t_clash();
        t_store();
        end_of_test();
    end
    // program ends within about a hundred cycles
    initial begin
        repeat (2000) @(posedge i_mclk);
        error_cnt++;
        end_of_test();
    end
endmodule : vliw_fetch_dispatch_core_tb
`default_nettype wire
